//--- hdl/pmrc_regs.vh
// register offsets, field positions, reset values and timing counts
// -----------------------------------------------------------------
// How it works
// RQ1: normal mode clocks units only while busy
// RQ2: idle stops core clock, peripherals keep running
// RQ3: any enabled interrupt ends idle
// RQ4: sleep gates functions after DRAM self-refresh
// RQ5: sleep wake takes 10 ms or 160 ms
// RQ6: merge reset sources, allow software reset
// RQ7: record cause of most recent reset
// RQ8: fourth timer comparator drives watchdog reset
// RQ9: real-time clock on trimmed slow tick
// RQ10: software requests modes, sleep waits refresh ack
// -----------------------------------------------------------------
`ifndef PMRC_REGS_VH
`define PMRC_REGS_VH

// apb byte addresses
`define PMRC_A_CTRL    8'h00
`define PMRC_A_STATE   8'h04
`define PMRC_A_CAUSE   8'h08
`define PMRC_A_ISTAT   8'h0C
`define PMRC_A_IMASK   8'h10
`define PMRC_A_WAKEEN  8'h14
`define PMRC_A_OSCNT   8'h18
`define PMRC_A_MATCH0  8'h1C
`define PMRC_A_RTCCNT  8'h2C
`define PMRC_A_RTCALM  8'h30
`define PMRC_A_RTCTRIM 8'h34

// control field positions
`define PMRC_C_IDLE    0
`define PMRC_C_SLEEP   1
`define PMRC_C_SWRST   2
`define PMRC_C_KEEPOSC 3
`define PMRC_C_WDEN    4

// reset cause bits (one-hot)
`define PMRC_K_HARD    0
`define PMRC_K_SOFT    1
`define PMRC_K_WDOG    2
`define PMRC_K_SLEEP   3

// interrupt status bits
`define PMRC_I_MATCH0  0
`define PMRC_I_RTCSEC  3
`define PMRC_I_RTCALM  4
`define PMRC_I_IDLEX   5
`define PMRC_I_WAKE    6

// reset values
`define PMRC_RV_CAUSE  4'h1
`define PMRC_RV_TRIM   16'h7FFF

// timing
`define PMRC_CLK_HZ    100000000
`define PMRC_CLK_MHZ   100
`define PMRC_SLOW_HZ   32768
`define PMRC_FAST_HZ   3686400
`define PMRC_WAKE_FAST_US 10000
`define PMRC_WAKE_SLOW_US 160000
`define PMRC_RST_CYC   16

`endif

//--- hdl/pmrc_rtc.v
// real-time clock with slow tick divider and trim
`timescale 1ns/100ps
`default_nettype none
`include "pmrc_regs.vh"

module pmrc_rtc
(
  input  wire        i_sys_clk,    // system clock
  input  wire        i_rst,        // async reset, high
  input  wire [15:0] i_trim,       // slow ticks per second minus one
  input  wire        i_wr_cnt,     // software load of seconds
  input  wire [31:0] i_wdata,      // load value
  input  wire [31:0] i_alarm,      // alarm compare value
  output reg  [31:0] o_count,      // seconds count
  output reg         o_sec,        // one-cycle second pulse
  output reg         o_alarm       // one-cycle alarm pulse
);
  // -----------------------------------------------------------------
  // slow tick and trimmed prescaler
  // -----------------------------------------------------------------
  localparam DIV = `PMRC_CLK_HZ / `PMRC_SLOW_HZ - 1;
  reg  [15:0] div_cnt;             // system to slow divider
  reg  [15:0] pre_cnt;             // slow ticks within a second
  wire        tick = (div_cnt == DIV[15:0]);
  wire        sec  = tick && (pre_cnt >= i_trim);

  // runs in every mode, sleep included
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      div_cnt <= 16'h0000;
      pre_cnt <= 16'h0000;
    end
    else
    begin
      div_cnt <= tick ? 16'h0000 : div_cnt + 16'h0001;
      if (sec)
        pre_cnt <= 16'h0000;          // RQ9
      else if (tick)
        pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  // seconds counter and alarm compare
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_count <= 32'h0000_0000;
      o_sec   <= 1'b0;
      o_alarm <= 1'b0;
    end
    else
    begin
      o_sec   <= sec;
      o_alarm <= sec && ((o_count + 32'h0000_0001) == i_alarm);
      if (i_wr_cnt)
        o_count <= i_wdata;
      else if (sec)
        o_count <= o_count + 32'h0000_0001; // RQ9
    end
  end
endmodule // pmrc_rtc
`default_nettype wire

//--- hdl/pmrc_timer.v
// free-running system timer with four match comparators
`timescale 1ns/100ps
`default_nettype none
`include "pmrc_regs.vh"

module pmrc_timer
(
  input  wire         i_sys_clk,   // system clock
  input  wire         i_rst,       // async reset, high
  input  wire         i_run,       // fast oscillator running
  input  wire         i_wr_cnt,    // software load of counter
  input  wire [31:0]  i_wdata,     // load value
  input  wire [127:0] i_match,     // four match values, ch0 low
  output reg  [31:0]  o_count,     // counter value
  output reg  [3:0]   o_hit        // one-cycle match pulses
);
  // -----------------------------------------------------------------
  // tick divider: fast oscillator rate from system clock
  // -----------------------------------------------------------------
  localparam DIV = `PMRC_CLK_HZ / `PMRC_FAST_HZ - 1;
  reg  [15:0] div_cnt;             // divider count
  wire        tick = i_run && (div_cnt == DIV[15:0]);
  wire [31:0] next_count = o_count + 32'h0000_0001;

  // divider only advances while the oscillator would run
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      div_cnt <= 16'h0000;
    else if (!i_run || tick)
      div_cnt <= 16'h0000;
    else
      div_cnt <= div_cnt + 16'h0001;
  end

  // counter: software load wins over a tick
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_count <= 32'h0000_0000;
    else if (i_wr_cnt)
      o_count <= i_wdata;
    else if (tick)
      o_count <= next_count;
  end

  // -----------------------------------------------------------------
  // comparators, one per channel; channel 3 feeds the watchdog
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_cmp
      always @(posedge i_sys_clk or posedge i_rst)
      begin
        if (i_rst)
          o_hit[g] <= 1'b0;
        else
          o_hit[g] <= tick && (next_count == i_match[32*g +: 32]); // RQ8
      end
    end
  endgenerate
endmodule // pmrc_timer
`default_nettype wire

//--- hdl/pmrc_top.v
// power-mode and reset control block with apb registers
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pmrc_regs.vh"

module pmrc_top
#(
  parameter N_UNIT     = 4,                                    // gated units
  parameter WAKE_FAST  = `PMRC_WAKE_FAST_US * `PMRC_CLK_MHZ,   // 10 ms
  parameter WAKE_SLOW  = `PMRC_WAKE_SLOW_US * `PMRC_CLK_MHZ    // 160 ms
)
(
  input  wire              i_sys_clk,       // system clock
  input  wire              i_rst,           // hard reset, async high
  input  wire              psel,            // apb select
  input  wire              penable,         // apb access phase
  input  wire              pwrite,          // apb direction
  input  wire [7:0]        paddr,           // apb byte address
  input  wire [31:0]       pwdata,          // apb write data
  output wire              pready,          // apb ready
  output reg  [31:0]       prdata,          // apb read data
  output wire              pslverr,         // apb error
  input  wire [N_UNIT-1:0] i_unit_busy,     // unit wants its clock
  input  wire              i_int_pending,   // enabled interrupt at controller
  input  wire [6:0]        i_wake_src,      // external wake sources
  input  wire              i_sref_ack,      // dram in self-refresh
  output wire              o_cpu_clk_en,    // core clock enable
  output wire [N_UNIT-1:0] o_unit_clk_en,   // peripheral clock enables
  output wire              o_func_en,       // functions powered
  output wire              o_fast_osc_en,   // fast oscillator enable
  output reg               o_sref_req,      // self-refresh request
  output wire              o_sys_rst,       // internal reset
  output wire              o_irq            // block interrupt
);
  // -----------------------------------------------------------------
  // mode states
  // -----------------------------------------------------------------
  localparam [2:0] ST_NORM  = 3'h0;  // full on
  localparam [2:0] ST_IDLE  = 3'h1;  // core clock stopped
  localparam [2:0] ST_SREF  = 3'h2;  // waiting self-refresh ack
  localparam [2:0] ST_SLEEP = 3'h3;  // functions off; rtc runs, fast osc too if kept
  localparam [2:0] ST_WAKE  = 3'h4;  // oscillator settle

  reg  [2:0]   state;                // mode state
  reg  [2:0]   next_state;           // mode next value
  reg  [23:0]  wake_cnt;             // wake latency count
  reg          keep_osc;             // fast oscillator kept in sleep
  reg          wd_en;                // watchdog armed
  reg  [3:0]   cause;                // last reset cause, one-hot
  reg  [6:0]   istat;                // sticky interrupt status
  reg  [6:0]   imask;                // interrupt mask
  reg  [7:0]   wake_en;              // wake source enables
  reg  [127:0] match;                // timer match values
  reg  [31:0]  rtc_alarm;            // rtc alarm value
  reg  [15:0]  rtc_trim;             // rtc trim
  reg  [4:0]   rst_cnt;              // internal reset stretch
  reg          osc_at_sleep;         // osc kept at sleep entry
  wire [31:0]  os_count;             // timer value
  wire [3:0]   os_hit;               // match pulses
  wire [31:0]  rtc_count;            // rtc seconds
  wire         rtc_sec;              // second pulse
  wire         rtc_alm;              // alarm pulse

  // -----------------------------------------------------------------
  // apb decode; always ready, no wait states
  // -----------------------------------------------------------------
  wire acc  = psel && penable;
  wire wr   = acc && pwrite;
  wire rd   = acc && !pwrite;
  wire a_match = (paddr >= `PMRC_A_MATCH0) && (paddr < `PMRC_A_RTCCNT)
                 && (paddr[1:0] == 2'b00);
  wire [1:0] msel = paddr[3:2] - 2'h3;        // 0x1C maps to channel 0
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `PMRC_A_RTCTRIM);

  assign pready  = 1'b1;
  assign pslverr = acc && !mapped;            // unmapped address

  wire wr_ctrl  = wr && (paddr == `PMRC_A_CTRL);
  wire idle_req = wr_ctrl && pwdata[`PMRC_C_IDLE];   // RQ10
  wire slp_req  = wr_ctrl && pwdata[`PMRC_C_SLEEP];  // RQ10
  wire sw_rst   = wr_ctrl && pwdata[`PMRC_C_SWRST];  // RQ6
  wire wd_rst   = wd_en && os_hit[3];                // RQ8

  // wake decision: rtc alarm is wake source 0
  wire [7:0] wake_vec = {i_wake_src, rtc_alm};
  wire       wake_hit = |(wake_en & wake_vec);       // RQ5
  wire [23:0] wake_len = osc_at_sleep ? WAKE_FAST[23:0] : WAKE_SLOW[23:0];
  wire       wake_done = (state == ST_WAKE) && (wake_cnt == wake_len - 24'h1);

  // -----------------------------------------------------------------
  // mode sequencer, next state
  // -----------------------------------------------------------------
  always @*
  begin
    next_state = state;
    case (state)
      ST_NORM:
        if (slp_req)
          next_state = ST_SREF;                    // RQ4
        else if (idle_req)
          next_state = ST_IDLE;                    // RQ2
      ST_IDLE:
        if (i_int_pending || o_irq)
          next_state = ST_NORM;                    // RQ3
      ST_SREF:
        if (i_sref_ack)
          next_state = ST_SLEEP;                   // RQ10
      ST_SLEEP:
        if (wake_hit)
          next_state = ST_WAKE;                    // RQ5
      ST_WAKE:
        if (wake_done)
          next_state = ST_NORM;
      default:
        next_state = ST_NORM;
    endcase
  end

  // state register; watchdog or software reset returns to normal
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      state <= ST_NORM;
    else if (sw_rst || wd_rst)
      state <= ST_NORM;
    else
      state <= next_state;
  end

  // wake latency counter, only live in the wake state
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      wake_cnt <= 24'h000000;
    else if (state == ST_WAKE)
      wake_cnt <= wake_cnt + 24'h000001;           // RQ5
    else
      wake_cnt <= 24'h000000;
  end

  // self-refresh held from request until wake completes or a software or watchdog reset
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sref_req   <= 1'b0;
      osc_at_sleep <= 1'b1;
    end
    else if (state == ST_NORM && slp_req)
    begin
      o_sref_req   <= 1'b1;                        // RQ4
      osc_at_sleep <= keep_osc;
    end
    else if (wake_done || sw_rst || wd_rst)
      o_sref_req <= 1'b0;
  end

  // -----------------------------------------------------------------
  // clock and power enables
  // -----------------------------------------------------------------
  // functions stay on until refresh is acked, then off until the osc has settled
  assign o_func_en     = (state == ST_NORM) || (state == ST_IDLE) ||
                         (state == ST_SREF);                          // RQ4
  assign o_cpu_clk_en  = (state == ST_NORM) || (state == ST_SREF);    // RQ2
  assign o_unit_clk_en = {N_UNIT{o_func_en}} & i_unit_busy;           // RQ1
  // fast osc only dropped in sleep when software chose so
  assign o_fast_osc_en = !(state == ST_SLEEP && !osc_at_sleep);       // RQ5

  // -----------------------------------------------------------------
  // reset merge and cause record
  // -----------------------------------------------------------------
  localparam RST_LEN = `PMRC_RST_CYC;

  // stretch any source; hard reset loads the full count
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      rst_cnt <= RST_LEN[4:0];                     // RQ6
    else if (sw_rst || wd_rst || wake_done)
      rst_cnt <= RST_LEN[4:0];                     // RQ6
    else if (rst_cnt != 5'h00)
      rst_cnt <= rst_cnt - 5'h01;
  end
  assign o_sys_rst = i_rst || (rst_cnt != 5'h00);  // RQ6

  // cause: newest event wins, software clears with ones
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      cause <= `PMRC_RV_CAUSE;                     // RQ7
    else if (wd_rst)
      cause <= 4'h1 << `PMRC_K_WDOG;               // RQ7
    else if (sw_rst)
      cause <= 4'h1 << `PMRC_K_SOFT;               // RQ7
    else if (wake_done)
      cause <= 4'h1 << `PMRC_K_SLEEP;              // RQ7
    else if (wr && paddr == `PMRC_A_CAUSE)
      cause <= cause & ~pwdata[3:0];
  end

  // -----------------------------------------------------------------
  // interrupt status: read clears, a new event wins over the clear
  // -----------------------------------------------------------------
  wire [6:0] ev = {wake_done, (state == ST_IDLE && next_state == ST_NORM),
                   rtc_alm, rtc_sec, os_hit[2:0]};
  wire       rd_stat = rd && (paddr == `PMRC_A_ISTAT);

  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      istat <= 7'h00;
    else if (rd_stat)
      istat <= ev;                                 // clear, keep new sets
    else
      istat <= istat | ev;
  end
  assign o_irq = |(istat & imask);

  // -----------------------------------------------------------------
  // software-written registers
  // -----------------------------------------------------------------
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      keep_osc  <= 1'b1;
      wd_en     <= 1'b0;
      imask     <= 7'h00;
      wake_en   <= 8'h00;
      match     <= 128'h0;
      rtc_alarm <= 32'h0000_0000;
      rtc_trim  <= `PMRC_RV_TRIM;
    end
    else
    begin
      if (wd_rst || sw_rst)
        wd_en <= 1'b0;                   // disarm so reset is not repeated
      else if (wr_ctrl)
      begin
        keep_osc <= pwdata[`PMRC_C_KEEPOSC];
        wd_en    <= pwdata[`PMRC_C_WDEN];          // RQ8
      end
      if (wr && paddr == `PMRC_A_IMASK)
        imask <= pwdata[6:0];
      if (wr && paddr == `PMRC_A_WAKEEN)
        wake_en <= pwdata[7:0];
      if (wr && a_match)
        match[32*msel +: 32] <= pwdata;
      if (wr && paddr == `PMRC_A_RTCALM)
        rtc_alarm <= pwdata;
      if (wr && paddr == `PMRC_A_RTCTRIM)
        rtc_trim <= pwdata[15:0];                  // RQ9
    end
  end

  // -----------------------------------------------------------------
  // read mux, registered during the setup cycle
  // -----------------------------------------------------------------
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0000_0000;
      if (a_match)
        prdata <= match[32*msel +: 32];
      else
        case (paddr)
          `PMRC_A_CTRL:    prdata <= {27'h0, wd_en, keep_osc, 3'h0};
          `PMRC_A_STATE:   prdata <= {29'h0, state};
          `PMRC_A_CAUSE:   prdata <= {28'h0, cause};
          `PMRC_A_ISTAT:   prdata <= {25'h0, istat};
          `PMRC_A_IMASK:   prdata <= {25'h0, imask};
          `PMRC_A_WAKEEN:  prdata <= {24'h0, wake_en};
          `PMRC_A_OSCNT:   prdata <= os_count;
          `PMRC_A_RTCCNT:  prdata <= rtc_count;
          `PMRC_A_RTCALM:  prdata <= rtc_alarm;
          `PMRC_A_RTCTRIM: prdata <= {16'h0, rtc_trim};
          default:         prdata <= 32'h0000_0000;
        endcase
    end
  end

  // -----------------------------------------------------------------
  // timer and real-time clock
  // -----------------------------------------------------------------
  pmrc_timer u_timer
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_run     (o_fast_osc_en),
    .i_wr_cnt  (wr && paddr == `PMRC_A_OSCNT),
    .i_wdata   (pwdata),
    .i_match   (match),
    .o_count   (os_count),
    .o_hit     (os_hit)
  );

  pmrc_rtc u_rtc
  (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_trim    (rtc_trim),
    .i_wr_cnt  (wr && paddr == `PMRC_A_RTCCNT),
    .i_wdata   (pwdata),
    .i_alarm   (rtc_alarm),
    .o_count   (rtc_count),
    .o_sec     (rtc_sec),
    .o_alarm   (rtc_alm)
  );
endmodule // pmrc_top
`default_nettype wire

//--- testbench/pmrc_dram_model.sv
// dram controller stand-in that answers self-refresh requests
`timescale 1ns/100ps
`default_nettype none
module pmrc_dram_model
(
  input  wire logic       i_sys_clk,   // system clock
  input  wire logic       i_rst,       // async reset, high
  input  wire logic       i_sref_req,  // self-refresh request
  input  wire logic [7:0] i_delay,     // answer delay in cycles
  output var  logic       o_sref_ack   // in self-refresh
);
  logic [7:0] wait_cnt;  // cycles since request
  // ack only after the request and its delay; a slow answer tests the wait
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_sref_ack <= 1'b0;
      wait_cnt   <= 8'h00;
    end
    else if (!i_sref_req)  // leave refresh at once
    begin
      o_sref_ack <= 1'b0;
      wait_cnt   <= 8'h00;
    end
    else if (wait_cnt >= i_delay)
      o_sref_ack <= 1'b1;
    else
      wait_cnt <= wait_cnt + 8'h01;
  end
endmodule // pmrc_dram_model
`default_nettype wire

//--- testbench/pmrc_properties.sv
// concurrent checks on the power-mode and reset control ports
`timescale 1ns/100ps
`default_nettype none
module pmrc_properties
#(
  parameter N_UNIT = 4  // gated units
)
(
  input wire logic              i_sys_clk,
  input wire logic              i_rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [N_UNIT-1:0] i_unit_busy,
  input wire logic              i_int_pending,
  input wire logic              i_sref_ack,
  input wire logic              o_cpu_clk_en,
  input wire logic [N_UNIT-1:0] o_unit_clk_en,
  input wire logic              o_func_en,
  input wire logic              o_fast_osc_en,
  input wire logic              o_sref_req,
  input wire logic              o_sys_rst,
  input wire logic              o_irq
);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  sequence s_idle;  // core halted, functions up
    o_func_en && !o_cpu_clk_en;
  endsequence
  sequence s_stretch;  // sixteen cycles of reset, then release
    o_sys_rst[*8] ##1 o_sys_rst[*8] ##1 !o_sys_rst;
  endsequence
  property p_unit_gate;
    o_unit_clk_en == (i_unit_busy & {N_UNIT{o_func_en}});
  endproperty
  property p_idle_units;
    s_idle |-> o_unit_clk_en == i_unit_busy;
  endproperty
  property p_idle_exit;
    s_idle ##0 (i_int_pending || o_irq) |=> o_cpu_clk_en;
  endproperty
  property p_off_after_ack;
    $fell(o_func_en) |-> $past(i_sref_ack) && o_sref_req;
  endproperty
  property p_hold_for_ack;
    o_sref_req && !i_sref_ack |=> o_func_en;
  endproperty
  property p_osc_sleep;
    !o_fast_osc_en |-> !o_func_en;
  endproperty
  property p_stretch;
    $rose(o_sys_rst) |-> s_stretch;
  endproperty
  property p_wake_rst;
    $rose(o_func_en) |-> ##[0:1] o_sys_rst;
  endproperty
  property p_err_phase;
    pslverr |-> psel && penable && pready;
  endproperty
  a_unit_gate: assert property (p_unit_gate) else $error("unit clock gate wrong");
  a_idle_units: assert property (p_idle_units) else $error("idle unit clocks");
  a_idle_exit: assert property (p_idle_exit) else $error("idle not left");
  a_off_after_ack: assert property (p_off_after_ack) else $error("off without ack");
  a_hold_for_ack: assert property (p_hold_for_ack) else $error("gated early");
  a_osc_sleep: assert property (p_osc_sleep) else $error("osc off outside sleep");
  a_stretch: assert property (p_stretch) else $error("reset stretch length");
  a_wake_rst: assert property (p_wake_rst) else $error("no sleep reset");
  a_err_phase: assert property (p_err_phase) else $error("error outside access");
endmodule // pmrc_properties

bind pmrc_top pmrc_properties #(.N_UNIT(N_UNIT)) i_props (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .i_unit_busy(i_unit_busy), .i_int_pending(i_int_pending), .i_sref_ack(i_sref_ack),
  .o_cpu_clk_en(o_cpu_clk_en), .o_unit_clk_en(o_unit_clk_en), .o_func_en(o_func_en),
  .o_fast_osc_en(o_fast_osc_en), .o_sref_req(o_sref_req), .o_sys_rst(o_sys_rst),
  .o_irq(o_irq));
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the power-mode and reset control block
`timescale 1ns/100ps
`default_nettype none
`include "pmrc_regs.vh"
`define CHK(nm, exp, got) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module tb;
  localparam WF = 20;  // shortened fast wake
  localparam WS = 50;  // shortened slow wake
  logic i_sys_clk, i_rst, psel, penable, pwrite, pready, pslverr, err;
  logic i_int_pending, i_sref_ack, o_cpu_clk_en, o_func_en, o_fast_osc_en;
  logic o_sref_req, o_sys_rst, o_irq;
  logic [3:0] i_unit_busy, o_unit_clk_en;
  logic [6:0] i_wake_src;
  logic [7:0] paddr, dly;
  logic [31:0] pwdata, prdata, rd;
  int num_errors, total_checks, cycles, n;
  pmrc_top #(.WAKE_FAST(WF), .WAKE_SLOW(WS)) i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .i_unit_busy(i_unit_busy),
    .i_int_pending(i_int_pending), .i_wake_src(i_wake_src), .i_sref_ack(i_sref_ack),
    .o_cpu_clk_en(o_cpu_clk_en), .o_unit_clk_en(o_unit_clk_en), .o_func_en(o_func_en),
    .o_fast_osc_en(o_fast_osc_en), .o_sref_req(o_sref_req), .o_sys_rst(o_sys_rst),
    .o_irq(o_irq));
  pmrc_dram_model i_dram (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sref_req(o_sref_req),
    .i_delay(dly), .o_sref_ack(i_sref_ack));
  // ----------------------------------------
  // clock, hang guard, verdict
  // ----------------------------------------
  initial
  begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 20000)  // whole run needs about 7000
    begin
      num_errors++;
      wrap_up();
    end
  end
  task wrap_up();
    if (num_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task tick(input int k);  // land just after the k-th edge
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  // one apb transfer; waits on pready, never assumes a latency
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do @(posedge i_sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_rtc();  // two slow ticks per second
    apb(0, `PMRC_A_RTCTRIM, 0);
    `CHK("trim rst", 32'h7FFF, rd)
    apb(1, `PMRC_A_RTCTRIM, 32'h1);
    apb(0, `PMRC_A_ISTAT, 0);
    tick(6200);
    apb(0, `PMRC_A_ISTAT, 0);
    `CHK("rtc second", 1'b1, rd[3])
  endtask
  task t_regs();  // cause reset, clear, unmapped place
    apb(0, `PMRC_A_CAUSE, 0);
    `CHK("cause hard", 32'h1, rd)
    apb(1, `PMRC_A_CAUSE, 32'h1);
    apb(0, `PMRC_A_CAUSE, 0);
    `CHK("cause clr", 32'h0, rd)
    apb(0, 8'h40, 0);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h0, rd)
  endtask
  task t_units();
    for (int b = 0; b < 16; b++)
    begin
      @(posedge i_sys_clk);
      i_unit_busy <= b[3:0];
      #1;
      `CHK("unit clk", b[3:0], o_unit_clk_en)
      `CHK("cpu clk", 1'b1, o_cpu_clk_en)
    end
  endtask
  task t_idle();  // idle entry, interrupt exit, mask and clear
    apb(1, `PMRC_A_IMASK, 32'h20);
    apb(1, `PMRC_A_CTRL, 32'h9);
    tick(1);
    `CHK("cpu idle", 1'b0, o_cpu_clk_en)
    `CHK("units idle", 4'hF, o_unit_clk_en)
    apb(0, `PMRC_A_STATE, 0);
    `CHK("state idle", 32'h1, rd)
    `CHK("still idle", 1'b0, o_cpu_clk_en)
    @(posedge i_sys_clk);
    i_int_pending <= 1'b1;
    tick(2);
    `CHK("cpu back", 1'b1, o_cpu_clk_en)
    `CHK("irq exit", 1'b1, o_irq)
    i_int_pending <= 1'b0;
    apb(1, `PMRC_A_IMASK, 32'h0);
    `CHK("irq masked", 1'b0, o_irq)
    apb(1, `PMRC_A_IMASK, 32'h20);
    `CHK("irq unmasked", 1'b1, o_irq)
    apb(0, `PMRC_A_ISTAT, 0);
    `CHK("idle event", 1'b1, rd[5])
    `CHK("irq cleared", 1'b0, o_irq)
  endtask
  // sleep with the dram answering after dl cycles, woken by a source pin
  task t_sleep(input logic keep, input logic [7:0] dl, input int w);
    dly = dl;
    apb(1, `PMRC_A_WAKEEN, 32'h2);
    apb(1, `PMRC_A_CTRL, {keep, 3'b000});  // entry uses the stored keep
    apb(1, `PMRC_A_CTRL, {keep, 3'b010});
    for (n = 0; n < 300 && o_func_en !== 1'b0; n++) tick(1);
    `CHK("sref req", 1'b1, o_sref_req)
    `CHK("ack wait", 1'b1, n >= dl)
    `CHK("osc sleep", keep, o_fast_osc_en)
    `CHK("units off", 4'h0, o_unit_clk_en)
    @(posedge i_sys_clk);
    i_wake_src <= 7'h01;
    for (n = 0; n < 300 && o_func_en !== 1'b1; n++) tick(1);
    `CHK("wake time", 1'b1, n >= w && n <= w + 4)
    i_wake_src <= 7'h00;
    `CHK("sref off", 1'b0, o_sref_req)
    for (n = 0; n < 40 && o_sys_rst !== 1'b0; n++) tick(1);
    apb(0, `PMRC_A_CAUSE, 0);
    `CHK("cause sleep", 32'h8, rd)
    apb(1, `PMRC_A_CAUSE, 32'h8);
  endtask
  task t_soft();
    apb(1, `PMRC_A_CTRL, 32'hC);
    for (n = 0; n < 5 && o_sys_rst !== 1'b1; n++) tick(1);
    for (n = 0; n < 40 && o_sys_rst !== 1'b0; n++) tick(1);
    `CHK("soft len", 16, n)
    apb(0, `PMRC_A_CAUSE, 0);
    `CHK("cause soft", 32'h2, rd)
    apb(1, `PMRC_A_CAUSE, 32'h2);
  endtask
  task t_wdog();  // compare three hits after about 81 cycles
    apb(1, `PMRC_A_MATCH0 + 8'h0C, 32'h3);
    apb(1, `PMRC_A_OSCNT, 32'h0);
    apb(1, `PMRC_A_CTRL, 32'h18);
    for (n = 0; n < 400 && o_sys_rst !== 1'b1; n++) tick(1);
    `CHK("wdog reset", 1'b1, o_sys_rst)
    for (n = 0; n < 40 && o_sys_rst !== 1'b0; n++) tick(1);
    apb(0, `PMRC_A_CAUSE, 0);
    `CHK("cause wdog", 32'h4, rd)
  endtask
  initial
  begin
    i_rst = 1'b1;
    {psel, penable, pwrite, i_int_pending} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    i_unit_busy = 4'h0;
    i_wake_src = 7'h00;
    dly = 8'h00;
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_rtc();
    t_regs();
    t_units();
    t_idle();
    t_sleep(1'b1, 8'h00, WF);
    t_sleep(1'b0, 8'h28, WS);
    t_soft();
    t_wdog();
    wrap_up();
  end
endmodule // tb
`default_nettype wire
